//--- scm_ctrl.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "scm_defines.svh"
module scm_ctrl (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              apdu_start_i,
    input  wire scm_pkg::scm_byte_t p1_i,
    input  wire scm_pkg::scm_byte_t p2_i,
    input  wire logic              rx_vld_i,
    input  wire scm_pkg::scm_byte_t rx_byte_i,
    input  wire logic              apdu_end_i,
    input  wire logic              mac_ok_i,
    output logic                   tx_vld_o,
    output scm_pkg::scm_byte_t     tx_byte_o,
    output logic                   sw_vld_o,
    output scm_pkg::scm_sw_t       sw_o,
    input  wire scm_pkg::scm_sess_t xfer_sess_i,
    output logic [15:0]            xfer_size_o,
    output logic                   xfer_open_o,
    input  wire logic [3:0]        reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    input  wire logic              reg_we_i,
    input  wire logic              reg_re_i,
    output logic [31:0]            reg_rdata_o
);
    import scm_pkg::*;

    // Reserved bits clear and exactly one selecting bit set
    function automatic logic sel_ok(input scm_byte_t b);
        return (b[`SCM_SEL_RSVD] == 4'h0) && $onehot({b[7], b[2:0]});
    endfunction : sel_ok

    // Expected value length per tag; long form lengths are refused
    function automatic logic len_ok(input scm_byte_t tag,
                                    input scm_byte_t len,
                                    input logic term);
        if (term) begin
            return (tag == `SCM_TAG_MSA || tag == `SCM_TAG_CSA)
                && len == `SCM_LEN_TERM;
        end
        if (tag == `SCM_TAG_ALG) begin
            return len == `SCM_LEN_ALG;
        end
        if (tag == `SCM_TAG_CSA || tag == `SCM_TAG_MAC) begin
            return len == `SCM_LEN_ID;
        end
        if (tag == `SCM_TAG_SIZE) begin
            return len == 8'h01 || len == 8'h02;
        end
        return 1'b0;
    endfunction : len_ok

    scm_tbl_if tbl ();

    scm_byte_t    p1_reg;
    scm_byte_t    p2_reg;
    scm_ps_e      ps_reg;
    scm_ps_e      ps_next;
    scm_byte_t    tag_reg;
    scm_byte_t    rem_reg;
    logic [5:0]   idx_reg;
    logic         bad_reg;
    logic [3:0]   seen_reg;
    logic         msa_reg;
    logic         csa_reg;
    logic [3:0]   kset_reg;
    scm_byte_t    ciph_reg;
    scm_byte_t    integ_reg;
    logic [15:0]  csize_reg;
    logic [127:0] id_reg;
    logic         resp_rdy_reg;
    logic         resp_start_reg;
    scm_sess_t    resp_sess_reg;
    logic [3:0]   lock_reg;
    scm_sw_t      last_sw_reg;
    scm_tx_e      tx_reg;
    logic [1:0]   tx_cnt_reg;

    // Command decode
    logic is_start;
    logic is_term;
    logic is_cmd;
    logic is_rsp;
    logic p_ok;
    assign is_start = p1_reg == `SCM_P1_START;
    assign is_term  = p1_reg == `SCM_P1_TERM;
    assign is_cmd   = p2_reg == `SCM_P2_CMD;
    assign is_rsp   = p2_reg == `SCM_P2_RSP;
    assign p_ok     = (is_start || is_term) && (is_cmd || is_rsp);

    // Byte stream qualifiers
    logic       byte_in;
    logic       in_val;
    logic       last_val;
    logic [3:0] tag_bit;
    logic       bad_now;
    assign byte_in  = rx_vld_i && is_cmd;
    assign in_val   = byte_in && ps_reg == PS_VAL;
    assign last_val = in_val && rem_reg == 8'h01;
    assign tag_bit  = {tag_reg == `SCM_TAG_SIZE, tag_reg == `SCM_TAG_MAC,
                       tag_reg == `SCM_TAG_CSA, tag_reg == `SCM_TAG_ALG};

    // Outer tag 73, short length, and per-tag lengths
    assign bad_now = byte_in
        && ((ps_reg == PS_OTAG && rx_byte_i != `SCM_TAG_CMD)
         || (ps_reg == PS_OLEN && rx_byte_i[7])
         || (ps_reg == PS_LEN && !len_ok(tag_reg, rx_byte_i, is_term)));

    // TLV walk; a zero length value goes straight to the next tag
    always_comb begin
        ps_next = ps_reg;
        unique case (ps_reg)
            PS_OTAG: ps_next = PS_OLEN;
            PS_OLEN: ps_next = PS_TAG;
            PS_TAG:  ps_next = PS_LEN;
            PS_LEN:  ps_next = (rx_byte_i == 8'h00) ? PS_TAG : PS_VAL;
            PS_VAL:  ps_next = (rem_reg == 8'h01) ? PS_TAG : PS_VAL;
        endcase
    end

    // Header latch; every APDU restarts the parser
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            p1_reg <= 8'h00;
            p2_reg <= 8'h00;
            ps_reg <= PS_OTAG;
        end else if (apdu_start_i) begin
            p1_reg <= p1_i;
            p2_reg <= p2_i;
            ps_reg <= PS_OTAG;
        end else if (byte_in) begin
            ps_reg <= ps_next;
        end
    end

    // Tag, remaining length and value index
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tag_reg <= 8'h00;
            rem_reg <= 8'h00;
            idx_reg <= 6'h00;
        end else if (byte_in) begin
            if (ps_reg == PS_TAG) begin
                tag_reg <= rx_byte_i;
            end
            if (ps_reg == PS_LEN) begin
                rem_reg <= rx_byte_i;
                idx_reg <= 6'h00;
            end
            if (in_val) begin
                rem_reg <= rem_reg - 8'h01;
                idx_reg <= idx_reg + 6'h01;
            end
        end
    end

    // Presence flags, cleared per APDU; a missing TLV stays visible
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bad_reg  <= 1'b0;
            seen_reg <= 4'h0;
        end else if (apdu_start_i) begin
            bad_reg  <= 1'b0;
            seen_reg <= 4'h0;
        end else begin
            bad_reg  <= bad_reg | bad_now;
            seen_reg <= seen_reg | (last_val ? tag_bit : 4'h0);
        end
    end

    // Value capture: selection bytes, identifier, container size
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ciph_reg  <= 8'h00;
            integ_reg <= 8'h00;
            id_reg    <= 128'h0;
            csize_reg <= 16'h0000;
        end else if (in_val) begin
            if (tag_bit[0] && idx_reg == 6'h00) begin
                ciph_reg <= rx_byte_i;
            end
            if (tag_bit[0] && idx_reg == 6'h01) begin
                integ_reg <= rx_byte_i;
            end
            if ((tag_bit[1] || tag_reg == `SCM_TAG_MSA) && idx_reg < 6'h10) begin
                id_reg <= {id_reg[119:0], rx_byte_i}; // Identifier is the first 16 bytes
            end
            if (tag_bit[3]) begin
                csize_reg <= {csize_reg[7:0], rx_byte_i};
            end
        end
    end

    // Terminate list: the identifier is complete by the MAC's last byte
    assign tbl.look_id = id_reg;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            msa_reg  <= 1'b0;
            csa_reg  <= 1'b0;
            kset_reg <= 4'h0;
        end else if (apdu_start_i) begin
            msa_reg  <= 1'b0;
            csa_reg  <= 1'b0;
            kset_reg <= 4'h0;
        end else if (last_val && is_term) begin
            msa_reg  <= msa_reg | (tag_reg == `SCM_TAG_MSA);
            csa_reg  <= csa_reg | tag_bit[1];
            kset_reg <= kset_reg | (tag_bit[1] ? tbl.look_hit : 4'h0);
        end
    end

    // Verdicts at the end of a command block
    logic       parse_done;
    logic       start_fmt;
    logic       term_fmt;
    logic [3:0] term_set;
    logic       end_cmd;
    logic       end_rsp;
    logic       have;
    scm_sw_t    sw_cmd;
    assign parse_done = ps_reg == PS_TAG && !bad_reg;
    assign start_fmt  = parse_done && seen_reg == 4'hF && sel_ok(ciph_reg)
                        && sel_ok(integ_reg) && csize_reg != 16'h0000;
    // A master TLV alone or connection TLVs only; a mix is refused
    assign term_fmt   = parse_done && (msa_reg ^ csa_reg);
    // Only one master association is tracked, so it covers every open slot
    assign term_set   = msa_reg ? tbl.valid : kset_reg;
    assign end_cmd    = apdu_end_i && !(p_ok && is_rsp);
    assign end_rsp    = apdu_end_i && p_ok && is_rsp;
    assign have       = resp_rdy_reg && resp_start_reg == is_start;

    // Status word choice
    assign sw_cmd = !p_ok                ? `SCM_SW_P1P2 :
                    is_start             ? (!start_fmt ? `SCM_SW_DATA :
                                            !mac_ok_i  ? `SCM_SW_MAC  :
                                            tbl.full   ? `SCM_SW_FULL : `SCM_SW_OK) :
                    !term_fmt            ? `SCM_SW_DATA :
                    !mac_ok_i            ? `SCM_SW_MAC  :
                    |(term_set & lock_reg) ? `SCM_SW_TERM : `SCM_SW_OK;

    // State changes only on a well-formed command with a good MAC; locked slots survive
    assign tbl.alloc      = end_cmd && p_ok && is_start && start_fmt && mac_ok_i
                            && !tbl.full;
    assign tbl.alloc_id   = id_reg;
    assign tbl.alloc_size = csize_reg;
    assign tbl.kill       = (end_cmd && p_ok && is_term && term_fmt && mac_ok_i)
                            ? (term_set & ~lock_reg) : 4'h0;

    scm_assoc_tbl u_tbl (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .t           (tbl),
        .xfer_sess_i (xfer_sess_i),
        .xfer_size_o (xfer_size_o),
        .xfer_open_o (xfer_open_o)
    );

    // Pending response: one per successful command, dropped by any other command
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            resp_rdy_reg   <= 1'b0;
            resp_start_reg <= 1'b0;
            resp_sess_reg  <= 2'h0;
        end else if (end_cmd) begin
            resp_rdy_reg   <= sw_cmd == `SCM_SW_OK;
            resp_start_reg <= is_start;
            resp_sess_reg  <= tbl.free_sess;
        end else if (end_rsp) begin
            resp_rdy_reg   <= 1'b0;
        end
    end

    // Response bytes: 53 01 session, or 73 00 for terminate
    scm_byte_t rsp_byte;
    logic      tx_last;
    assign rsp_byte = resp_start_reg
        ? (tx_cnt_reg == 2'h0 ? `SCM_TAG_RSP :
           tx_cnt_reg == 2'h1 ? `SCM_LEN_RSP : {resp_sess_reg, 6'h00})
        : (tx_cnt_reg == 2'h0 ? `SCM_TAG_CMD : 8'h00);
    assign tx_last  = tx_cnt_reg == (resp_start_reg ? 2'h2 : 2'h1);

    // Fetch sequencer; status follows the last data byte
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_reg     <= TX_IDLE;
            tx_cnt_reg <= 2'h0;
        end else begin
            unique case (tx_reg)
                TX_IDLE: if (end_rsp && have) begin
                    tx_reg     <= TX_DATA;
                    tx_cnt_reg <= 2'h0;
                end
                TX_DATA: begin
                    tx_cnt_reg <= tx_cnt_reg + 2'h1;
                    if (tx_last) begin
                        tx_reg <= TX_SW;
                    end
                end
                TX_SW:   tx_reg <= TX_IDLE;
            endcase
        end
    end

    // Registered outputs toward the terminal side
    logic    sw_pulse;
    scm_sw_t sw_next;
    assign sw_pulse = end_cmd || (end_rsp && !have) || tx_reg == TX_SW;
    assign sw_next  = end_cmd ? sw_cmd : (tx_reg == TX_SW) ? `SCM_SW_OK : `SCM_SW_NORSP;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_vld_o  <= 1'b0;
            tx_byte_o <= 8'h00;
            sw_vld_o  <= 1'b0;
            sw_o      <= 16'h0000;
        end else begin
            tx_vld_o  <= tx_reg == TX_DATA;
            tx_byte_o <= (tx_reg == TX_DATA) ? rsp_byte : 8'h00;
            sw_vld_o  <= sw_pulse;
            sw_o      <= sw_pulse ? sw_next : sw_o;
        end
    end

    // Register file: lock mask steers termination, status shows the table
    logic [31:0] rd_mux;
    assign rd_mux = (reg_addr_i == `SCM_REG_CTRL)   ? {28'h0, lock_reg} :
                    (reg_addr_i == `SCM_REG_STATUS) ? {23'h0, resp_rdy_reg, 2'h0,
                                                       resp_sess_reg, tbl.valid} :
                    (reg_addr_i == `SCM_REG_LASTSW) ? {16'h0, last_sw_reg} : 32'h0;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lock_reg    <= `SCM_CTRL_RST;
            last_sw_reg <= `SCM_LASTSW_RST;
            reg_rdata_o <= 32'h0;
        end else begin
            if (reg_we_i && reg_addr_i == `SCM_REG_CTRL) begin
                lock_reg <= reg_wdata_i[3:0];
            end
            if (sw_pulse) begin
                last_sw_reg <= sw_next;
            end
            reg_rdata_o <= reg_re_i ? rd_mux : 32'h0;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_p1_decode_bad: assert property (
        end_cmd && !p_ok |=> sw_vld_o && sw_o == `SCM_SW_P1P2)
        else $error("unknown P1 or P2 not refused");

    a_start_rsp_tag: assert property (
        $rose(tx_vld_o) && resp_start_reg |-> tx_byte_o == `SCM_TAG_RSP
            ##1 tx_byte_o == `SCM_LEN_RSP)
        else $error("start response not wrapped in tag 53");

    a_session_byte: assert property (
        $rose(tx_vld_o) && resp_start_reg |-> ##2 tx_vld_o
            && tx_byte_o[5:0] == 6'h00 && tx_byte_o[`SCM_SESS_POS] == resp_sess_reg)
        else $error("session byte malformed");

    a_sel_decode: assert property (
        tbl.alloc |-> sel_ok(ciph_reg) && sel_ok(integ_reg))
        else $error("channel opened with bad selection bytes");

    a_term_mac_err: assert property (
        end_cmd && is_term && term_fmt && !mac_ok_i
            |-> tbl.kill == 4'h0 ##1 sw_vld_o && sw_o == `SCM_SW_MAC)
        else $error("bad terminate MAC not answered 98 62");

    a_term_absent_ok: assert property (
        end_cmd && p_ok && is_term && term_fmt && mac_ok_i && term_set == 4'h0
            |=> sw_o == `SCM_SW_OK)
        else $error("absent association not answered success");

    a_term_fail_err: assert property (
        end_cmd && p_ok && is_term && term_fmt && mac_ok_i
            && |(term_set & lock_reg) |=> sw_o == `SCM_SW_TERM)
        else $error("failed termination not reported");

    a_mixed_reject: assert property (
        end_cmd && p_ok && is_term && msa_reg && csa_reg
            |-> tbl.kill == 4'h0 ##1 sw_o == `SCM_SW_DATA)
        else $error("mixed master and connection list accepted");

    a_term_len32: assert property (
        byte_in && is_term && ps_reg == PS_LEN && rx_byte_i != `SCM_LEN_TERM
            |=> bad_reg)
        else $error("terminate TLV length other than 32 accepted");

    a_bad_start_keep: assert property (
        end_cmd && p_ok && is_start && !start_fmt
            |-> !tbl.alloc ##1 sw_o == `SCM_SW_DATA && $stable(tbl.valid))
        else $error("malformed start changed association state");

    c_start_ok:  cover property (tbl.alloc);
    c_term_ok:   cover property (tbl.kill != 4'h0 && sw_next == `SCM_SW_OK);
    c_mac_err:   cover property (sw_vld_o && sw_o == `SCM_SW_MAC);
    c_fetch_rsp: cover property (tx_reg == TX_SW && resp_start_reg);
endmodule : scm_ctrl
`default_nettype wire

//--- scm_defines.svh
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

// Command parameters
`define SCM_P1_START 8'h03
`define SCM_P1_TERM  8'h04
`define SCM_P2_CMD   8'h80
`define SCM_P2_RSP   8'hA0

// Tags and fixed lengths
`define SCM_TAG_CMD  8'h73
`define SCM_TAG_RSP  8'h53
`define SCM_TAG_ALG  8'h89
`define SCM_TAG_MSA  8'h88
`define SCM_TAG_CSA  8'h8B
`define SCM_TAG_MAC  8'h8D
`define SCM_TAG_SIZE 8'h8E
`define SCM_LEN_ALG  8'h02
`define SCM_LEN_ID   8'h10
`define SCM_LEN_TERM 8'h20
`define SCM_LEN_RSP  8'h01

// Field positions
`define SCM_SEL_RSVD 6:3
`define SCM_SESS_POS 7:6

// Status words
`define SCM_SW_OK    16'h9000
`define SCM_SW_MAC   16'h9862
`define SCM_SW_DATA  16'h6A80
`define SCM_SW_FULL  16'h6A84
`define SCM_SW_TERM  16'h6F00
`define SCM_SW_P1P2  16'h6B00
`define SCM_SW_NORSP 16'h6985

// Register offsets and reset values
`define SCM_REG_CTRL   4'h0
`define SCM_REG_STATUS 4'h4
`define SCM_REG_LASTSW 4'h8
`define SCM_CTRL_RST   4'h0
`define SCM_LASTSW_RST 16'h0000
`endif

//--- scm_pkg.sv
package scm_pkg;
    typedef logic [7:0]  scm_byte_t;
    typedef logic [1:0]  scm_sess_t;
    typedef logic [15:0] scm_sw_t;
    typedef enum logic [2:0] {PS_OTAG, PS_OLEN, PS_TAG, PS_LEN, PS_VAL} scm_ps_e;
    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_SW} scm_tx_e;
endpackage : scm_pkg

//--- scm_tbl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scm_tbl_if;
    logic         alloc;
    logic [127:0] alloc_id;
    logic [15:0]  alloc_size;
    logic [1:0]   free_sess;
    logic         full;
    logic [127:0] look_id;
    logic [3:0]   look_hit;
    logic [3:0]   kill;
    logic [3:0]   valid;
    modport ctl (output alloc, alloc_id, alloc_size, look_id, kill,
                 input free_sess, full, look_hit, valid);
    modport tbl (input alloc, alloc_id, alloc_size, look_id, kill,
                 output free_sess, full, look_hit, valid);
endinterface : scm_tbl_if
`default_nettype wire

//--- scm_assoc_tbl.sv
`timescale 1ns/1ps
`default_nettype none
module scm_assoc_tbl (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    scm_tbl_if.tbl           t,
    input  wire logic [1:0]  xfer_sess_i,
    output logic      [15:0] xfer_size_o,
    output logic             xfer_open_o
);
    import scm_pkg::*;

    logic [3:0]   valid_reg;
    logic [127:0] id_reg [4];
    logic [15:0]  size_reg [4];
    logic [3:0]   alloc_mask;

    // Lowest free slot wins, so session numbers are reused predictably
    assign t.free_sess = !valid_reg[0] ? 2'h0 :
                         !valid_reg[1] ? 2'h1 :
                         !valid_reg[2] ? 2'h2 : 2'h3;
    assign t.full      = &valid_reg;
    assign t.valid     = valid_reg;
    assign alloc_mask  = (t.alloc && !t.full) ? (4'h1 << t.free_sess) : 4'h0;

    // Identifier lookup against every open association
    genvar g;
    for (g = 0; g < 4; g++) begin : g_hit
        assign t.look_hit[g] = valid_reg[g] && (id_reg[g] == t.look_id);
    end

    // Kill and allocate never meet on one slot: a killed slot was open
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            valid_reg <= 4'h0;
        end else begin
            valid_reg <= (valid_reg & ~t.kill) | alloc_mask;
        end
    end

    // Session number is bound to its container size here
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                id_reg[i]   <= 128'h0;
                size_reg[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (alloc_mask[i]) begin
                    id_reg[i]   <= t.alloc_id;
                    size_reg[i] <= t.alloc_size;
                end
            end
        end
    end

    // Later data transfers look up the size of their session
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            xfer_size_o <= 16'h0000;
            xfer_open_o <= 1'b0;
        end else begin
            xfer_size_o <= size_reg[xfer_sess_i];
            xfer_open_o <= valid_reg[xfer_sess_i];
        end
    end

    a_size_binding: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (t.alloc && !t.full) |=> valid_reg[$past(t.free_sess)]
            && size_reg[$past(t.free_sess)] == $past(t.alloc_size))
        else $error("session not bound to container size");
endmodule : scm_assoc_tbl
`default_nettype wire

//--- scm_term_model.sv
`timescale 1ns/1ps
`default_nettype none
// Terminal model: one APDU at a time, next header after the status word or after 12 cycles without one
module scm_term_model (
    input  wire logic       clk_sys_i,
    input  wire logic       sw_vld_i,
    output logic            start_o,
    output logic [7:0]      p1_o,
    output logic [7:0]      p2_o,
    output logic            vld_o,
    output logic [7:0]      byte_o,
    output logic            end_o,
    output logic            mac_ok_o
);
    initial {start_o, p1_o, p2_o, vld_o, byte_o, end_o, mac_ok_o} = '0;
    // Header with P1/P2, Lc data bytes back to back, then end
    // Model has no channel field; returns after its handshake or after a 12-cycle wait
    task automatic apdu(input logic [7:0] a1, input logic [7:0] a2,
                        input logic [7:0] d[$], input logic m);
        int n;
        @(posedge clk_sys_i);
        start_o <= 1'b1;
        p1_o <= a1;
        p2_o <= a2;
        foreach (d[k]) begin
            @(posedge clk_sys_i);
            start_o <= 1'b0;
            vld_o <= 1'b1;
            byte_o <= d[k];
        end
        @(posedge clk_sys_i);
        start_o <= 1'b0;
        vld_o <= 1'b0;
        byte_o <= ~byte_o; // Released line shows the inverse of the byte it held before
        end_o <= 1'b1;
        mac_ok_o <= m;
        @(posedge clk_sys_i);
        end_o <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (sw_vld_i !== 1'b1 && n < 12);
    endtask : apdu
endmodule : scm_term_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import scm_pkg::*;
    typedef logic [7:0] scm_bq_t[$];
    logic clk_sys_i, rst_i, reg_we, reg_re, sw_vld, tx_vld, xfer_open;
    logic apdu_start, rx_vld, apdu_end, mac_ok;
    scm_byte_t p1, p2, rx_byte, tx_byte;
    scm_sw_t sw;
    scm_sess_t xfer_sess;
    logic [15:0] xfer_size, sizes [4];
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [127:0] ids [4];
    logic [16:0] exp_q[$];
    scm_bq_t d;
    int n_fail = 0, tests_run = 0, seed = 95466, cyc = 0;
    localparam logic [7:0] CODES [4] = '{8'h01, 8'h02, 8'h04, 8'h80};
    scm_ctrl uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .apdu_start_i(apdu_start), .p1_i(p1),
        .p2_i(p2), .rx_vld_i(rx_vld), .rx_byte_i(rx_byte), .apdu_end_i(apdu_end),
        .mac_ok_i(mac_ok), .tx_vld_o(tx_vld), .tx_byte_o(tx_byte), .sw_vld_o(sw_vld),
        .sw_o(sw), .xfer_sess_i(xfer_sess), .xfer_size_o(xfer_size), .xfer_open_o(xfer_open),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
        .reg_rdata_o(reg_rdata));
    scm_term_model u_term (.clk_sys_i(clk_sys_i), .sw_vld_i(sw_vld), .start_o(apdu_start),
        .p1_o(p1), .p2_o(p2), .vld_o(rx_vld), .byte_o(rx_byte), .end_o(apdu_end),
        .mac_ok_o(mac_ok));
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] e);
        tests_run++;
        if (seen !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, seen);
        end
    endtask : check
    task automatic wrap_up();
        check("pending notes", 16'(exp_q.size()), 16'h0000);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    // Watcher: every response byte or status word takes the oldest note
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc >= 5000) begin
            n_fail++;
            wrap_up();
        end else if (tx_vld === 1'b1 || sw_vld === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected output", 16'h0001, 16'h0000);
            end else begin
                check("output kind", {15'h0, sw_vld}, {15'h0, exp_q[0][16]});
                check("output value", sw_vld ? sw : {8'h00, tx_byte},
                      16'(exp_q.pop_front()));
            end
        end
    end
    // Append the low n bytes of v, most significant first
    task automatic put(input logic [255:0] v, input int n);
        for (int k = n - 1; k >= 0; k--) d.push_back(v[k*8 +: 8]);
    endtask : put
    function automatic logic [127:0] rnd128();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction : rnd128
    // One cipher bit, one integrity bit, 16-byte fields, small size
    task automatic sdata(input scm_byte_t c, input scm_byte_t i, input logic [127:0] id,
                         input logic [15:0] sz);
        d = '{};
        put({8'h73, 8'h2C, 8'h89, 8'h02, c, i, 8'h8B, 8'h10}, 8);
        put(id, 16);
        put(16'h8D10, 2);
        put(rnd128(), 16);
        put({8'h8E, 8'h02, sz}, 4);
    endtask : sdata
    // Terminate with one association TLV: tag, 32, identifier, MAC
    task automatic tdata(input scm_byte_t tag, input logic [127:0] id);
        d = '{};
        put({8'h73, 8'h22, tag, 8'h20}, 4);
        put(id, 16);
        put(rnd128(), 16);
    endtask : tdata
    task automatic go(input scm_byte_t a1, input scm_byte_t a2, input logic m, input scm_sw_t w);
        exp_q.push_back({1'b1, w});
        u_term.apdu(a1, a2, d, m);
    endtask : go
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys_i);
        reg_we <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys_i);
        reg_re <= 1'b0;
        @(posedge clk_sys_i);
        check("register read", reg_rdata[15:0] & {{7{a != 4'h4}}, 9'h10F}, e);
    endtask : reg_rd
    initial begin
        {reg_we, reg_re, reg_addr, reg_wdata, xfer_sess} = '0;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // Reserved selection bits are refused and allocate nothing
        sdata(8'h10, 8'h01, rnd128(), 16'h0010);
        go(8'h03, 8'h80, 1'b1, 16'h6A80);
        sdata(8'h01, 8'h40, rnd128(), 16'h0010);
        go(8'h03, 8'h80, 1'b1, 16'h6A80);
        reg_rd(4'h4, 16'h0000);
        // Every cipher and integrity code, then fetch the session byte
        for (int k = 0; k < 4; k++) begin
            ids[k] = rnd128();
            sizes[k] = 16'h0001 + 16'($random(seed) & 32'h0FFF);
            sdata(CODES[k], CODES[3-k], ids[k], sizes[k]);
            go(8'h03, 8'h80, 1'b1, 16'h9000);
            d = '{};
            exp_q.push_back(17'h00053);
            exp_q.push_back(17'h00001);
            exp_q.push_back({9'h000, 2'(k), 6'h00});
            go(8'h03, 8'hA0, 1'b1, 16'h9000);
        end
        xfer_sess <= 2'd2;
        repeat (2) @(posedge clk_sys_i);
        check("session open", {15'h0, xfer_open}, 16'h0001);
        check("container size", xfer_size, sizes[2]);
        sdata(8'h01, 8'h01, rnd128(), 16'h0010);
        go(8'h03, 8'h80, 1'b1, 16'h6A84);
        d = '{};
        go(8'h05, 8'h80, 1'b1, 16'h6B00);
        go(8'h03, 8'hA0, 1'b1, 16'h6985);
        // Locked session cannot close; bad MAC and absent id
        reg_wr(4'h0, 32'h1);
        tdata(8'h8B, ids[0]);
        go(8'h04, 8'h80, 1'b1, 16'h6F00);
        tdata(8'h8B, ids[1]);
        go(8'h04, 8'h80, 1'b0, 16'h9862);
        tdata(8'h8B, rnd128());
        go(8'h04, 8'h80, 1'b1, 16'h9000);
        // Master and connection TLVs mixed, then a short connection TLV
        tdata(8'h88, rnd128());
        put(16'h8B20, 2);
        put({ids[1], rnd128()}, 32);
        go(8'h04, 8'h80, 1'b1, 16'h6A80);
        tdata(8'h8B, ids[1]);
        d[3] = 8'h10;
        go(8'h04, 8'h80, 1'b1, 16'h6A80);
        reg_wr(4'h0, 32'h0);
        tdata(8'h88, rnd128());
        go(8'h04, 8'h80, 1'b1, 16'h9000);
        d = '{};
        exp_q.push_back(17'h00073);
        exp_q.push_back(17'h00000);
        go(8'h04, 8'hA0, 1'b1, 16'h9000);
        reg_rd(4'h4, 16'h0000);
        reg_rd(4'hC, 16'h0000);
        reg_rd(4'h8, 16'h9000);
        check("session closed", {15'h0, xfer_open}, 16'h0000);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
